/* common/ppp_pkg.sv */
// parallel printer port: shared constants and carrier types
// assumes one 125 MHz clock and the host bus sampled synchronously
package ppp_pkg;

  // ------------------------------------------------------------------
  // register offsets from the port base address
  // ------------------------------------------------------------------
  localparam logic [1:0] PPP_OFS_DATA = 2'h0; // printer_data_byte
  localparam logic [1:0] PPP_OFS_STATE = 2'h1; // printer_line_state, read only
  localparam logic [1:0] PPP_OFS_CTRL = 2'h2; // printer_line_control

  // ------------------------------------------------------------------
  // control field positions and reset values
  // ------------------------------------------------------------------
  localparam int PPP_CTL_STROBE = 0; // inverted onto strobe pin
  localparam int PPP_CTL_AUTOFEED = 1; // inverted onto line_feed_auto pin
  localparam int PPP_CTL_INIT = 2; // straight onto init pin
  localparam int PPP_CTL_CHOOSE = 3; // inverted onto choose_printer pin
  localparam int PPP_CTL_INTR = 4; // intr_allow
  localparam int PPP_CTL_DIR = 5; // port_direction, 1 = input
  localparam int PPP_CTL_WIDTH = 6; // stored control bits
  localparam logic [5:0] PPP_CTL_RST = 6'h00; // control after reset
  localparam logic [7:0] PPP_DATA_RST = 8'h00; // data byte after reset
  localparam logic [2:0] PPP_STATE_LOW = 3'h0; // unimplemented status bits
  localparam logic [1:0] PPP_CTL_HIGH = 2'h0; // hard wired control bits

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] addr; // register offset
    logic [7:0] wdata; // host write byte
    logic rd_n; // host_read_strobe, active low
    logic wr_n; // host_write_strobe, active low
  } ppp_host_req_t;

  typedef struct packed {
    logic fault_n; // low = printer error
    logic online; // high = printer selected
    logic sheet_exhausted; // high = out of paper
    logic ack_n; // character taken, low pulse
    logic busy; // high = printer busy
  } ppp_line_in_t;

endpackage

/* core/ppp_port.sv */
// parallel printer port: data, status and control byte registers
// assumes host strobes and printer inputs synchronous to CLK_IN;
// the bidirectional data wire is resolved outside from PRINTER_DATA_PINS_OE_N_OUT
//
// Summary of operation
// - data at 00H, latched on write rise
// - reset clears data byte, pins all zero
// - data read returns live pin levels
// - status at 01H, held during read strobe
// - status bits zero to two read low
// - status bit three is fault level
// - status bit four is online level
// - status bit five is paper end
// - status bit six is character taken
// - status bit seven is inverted busy
// - control at 02H, bits six, seven zero
// - control bit zero inverted onto strobe
// - control bit one inverted onto autofeed
// - control bit two straight onto init
// - control bit three inverted onto select
// - bit four allows interrupt on ack rise
// - bit five sets direction in extended mode
// - data, control read/write; status read only
`timescale 1ns/1ns
module ppp_port (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input ppp_pkg::ppp_host_req_t HOST_REQ_IN,
  output logic [7:0] RD_DATA_OUT,
  input ppp_pkg::ppp_line_in_t LINE_IN,
  input wire logic MODE_CONFIG_REG_IN,
  input wire logic [7:0] PRINTER_DATA_PINS_IN,
  output logic [7:0] PRINTER_DATA_PINS_OUT,
  output logic PRINTER_DATA_PINS_OE_N_OUT,
  output logic STROBE_N_OUT,
  output logic LINE_FEED_AUTO_N_OUT,
  output logic INIT_N_OUT,
  output logic CHOOSE_PRINTER_N_OUT,
  output logic IRQ_OUT
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data; // printer_data_byte
    logic [5:0] ctrl; // printer_line_control, low six bits
    logic [7:0] rdata; // read answer
    logic [7:0] wbus; // last byte seen while write strobe low
    logic [1:0] waddr; // offset seen while write strobe low
    logic wr_n_prev; // write strobe one cycle ago
    logic rd_n_prev; // read strobe one cycle ago
    logic ack_prev; // ack level one cycle ago
    logic irq; // interrupt request
    logic [7:0] pdo; // data pin drive
    logic oe_n; // data pin enable, low drives
    logic strobe_n; // strobe pin
    logic autofeed_n; // line_feed_auto pin
    logic init_n; // init pin
    logic choose_n; // choose_printer pin
  } ppp_state_t;

  ppp_state_t st_q; // registered state
  ppp_state_t st_d; // next state

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // status byte built from the printer inputs, no storage of its own
  function automatic logic [7:0] status_byte(input ppp_pkg::ppp_line_in_t l);
    status_byte = {~l.busy,
                   l.ack_n,
                   l.sheet_exhausted,
                   l.online,
                   l.fault_n,
                   ppp_pkg::PPP_STATE_LOW};
  endfunction

  // pins are released only in extended mode with input direction
  function automatic logic release_pins(input logic mode, input logic [5:0] c);
    release_pins = ~mode & c[ppp_pkg::PPP_CTL_DIR];
  endfunction

  logic wr_rise; // write strobe just released
  logic rd_start; // first cycle of a read
  logic ack_rise; // character-taken rising edge

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    wr_rise = HOST_REQ_IN.wr_n & ~st_q.wr_n_prev;
    rd_start = ~HOST_REQ_IN.rd_n & st_q.rd_n_prev;
    ack_rise = LINE_IN.ack_n & ~st_q.ack_prev;
    st_d.wr_n_prev = HOST_REQ_IN.wr_n;
    st_d.rd_n_prev = HOST_REQ_IN.rd_n;
    st_d.ack_prev = LINE_IN.ack_n;
    // bus byte may vanish with the strobe edge, so keep the last one seen low
    if (!HOST_REQ_IN.wr_n) begin
      st_d.wbus = HOST_REQ_IN.wdata;
      st_d.waddr = HOST_REQ_IN.addr;
    end
    // commit on the strobe's rising edge
    if (wr_rise) begin
      case (st_q.waddr)
        ppp_pkg::PPP_OFS_DATA: begin
          st_d.data = st_q.wbus;
        end
        ppp_pkg::PPP_OFS_CTRL: begin
          // upper two bits are dropped, they are hard wired
          st_d.ctrl = st_q.wbus[5:0];
        end
        default: begin
          // status is read only, spare offset ignored
          st_d.ctrl = st_q.ctrl;
        end
      endcase
    end
    // read answer
    if (!HOST_REQ_IN.rd_n) begin
      case (HOST_REQ_IN.addr)
        ppp_pkg::PPP_OFS_DATA: begin
          // live pin levels, one cycle of sampling, never the stored copy
          st_d.rdata = PRINTER_DATA_PINS_IN;
        end
        ppp_pkg::PPP_OFS_STATE: begin
          // snapshot at strobe start, frozen until the strobe ends
          if (rd_start || st_q.rd_n_prev) begin
            st_d.rdata = status_byte(LINE_IN);
          end
        end
        ppp_pkg::PPP_OFS_CTRL: begin
          st_d.rdata = {ppp_pkg::PPP_CTL_HIGH, st_q.ctrl};
        end
        default: begin
          st_d.rdata = 8'h00; // spare offset reads zero
        end
      endcase
    end else begin
      st_d.rdata = 8'h00; // idle bus answer
    end
    // interrupt: an ack rise wins over the clear by a status read
    if (!st_d.ctrl[ppp_pkg::PPP_CTL_INTR]) begin
      st_d.irq = 1'b0;
    end else if (ack_rise) begin
      st_d.irq = 1'b1;
    end else if (rd_start && HOST_REQ_IN.addr == ppp_pkg::PPP_OFS_STATE) begin
      st_d.irq = 1'b0;
    end
    // pin drivers follow the next register values, so no extra cycle
    st_d.pdo = st_d.data;
    st_d.oe_n = release_pins(MODE_CONFIG_REG_IN, st_d.ctrl);
    st_d.strobe_n = ~st_d.ctrl[ppp_pkg::PPP_CTL_STROBE];
    st_d.autofeed_n = ~st_d.ctrl[ppp_pkg::PPP_CTL_AUTOFEED];
    st_d.init_n = st_d.ctrl[ppp_pkg::PPP_CTL_INIT];
    st_d.choose_n = ~st_d.ctrl[ppp_pkg::PPP_CTL_CHOOSE];
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  // reset values mirror the decode above for data and control of zero
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_q.data <= ppp_pkg::PPP_DATA_RST;
      st_q.ctrl <= ppp_pkg::PPP_CTL_RST;
      st_q.rdata <= 8'h00;
      st_q.wbus <= 8'h00;
      st_q.waddr <= 2'h0;
      st_q.wr_n_prev <= 1'b1;
      st_q.rd_n_prev <= 1'b1;
      st_q.ack_prev <= 1'b1;
      st_q.irq <= 1'b0;
      st_q.pdo <= ppp_pkg::PPP_DATA_RST;
      st_q.oe_n <= 1'b0;
      st_q.strobe_n <= 1'b1;
      st_q.autofeed_n <= 1'b1;
      st_q.init_n <= 1'b0;
      st_q.choose_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs, each straight from a flip-flop
  // ------------------------------------------------------------------
  assign RD_DATA_OUT = st_q.rdata;
  assign PRINTER_DATA_PINS_OUT = st_q.pdo;
  assign PRINTER_DATA_PINS_OE_N_OUT = st_q.oe_n;
  assign STROBE_N_OUT = st_q.strobe_n;
  assign LINE_FEED_AUTO_N_OUT = st_q.autofeed_n;
  assign INIT_N_OUT = st_q.init_n;
  assign CHOOSE_PRINTER_N_OUT = st_q.choose_n;
  assign IRQ_OUT = st_q.irq;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  data_write_a: assert property (
    (wr_rise && st_q.waddr == ppp_pkg::PPP_OFS_DATA) |=>
      PRINTER_DATA_PINS_OUT == $past(st_q.wbus))
    else $error("data pins missed the written byte");

  data_reset_a: assert property (
    $fell(RST_IN) |-> PRINTER_DATA_PINS_OUT == 8'h00)
    else $error("data pins not zero after reset");

  data_live_a: assert property (
    (!HOST_REQ_IN.rd_n && HOST_REQ_IN.addr == ppp_pkg::PPP_OFS_DATA) |=>
      RD_DATA_OUT == $past(PRINTER_DATA_PINS_IN))
    else $error("data read not live pin level");

  status_hold_a: assert property (
    (!HOST_REQ_IN.rd_n && !st_q.rd_n_prev && $stable(HOST_REQ_IN.addr) &&
      HOST_REQ_IN.addr == ppp_pkg::PPP_OFS_STATE) ##1
      (!HOST_REQ_IN.rd_n && $stable(HOST_REQ_IN.addr)) |=> $stable(RD_DATA_OUT))
    else $error("status changed during read strobe");

  status_bits_a: assert property (
    (rd_start && HOST_REQ_IN.addr == ppp_pkg::PPP_OFS_STATE) |=>
      RD_DATA_OUT == {~$past(LINE_IN.busy), $past(LINE_IN.ack_n),
        $past(LINE_IN.sheet_exhausted), $past(LINE_IN.online),
        $past(LINE_IN.fault_n), 3'h0})
    else $error("status byte mismatch");

  ctrl_high_a: assert property (
    (!HOST_REQ_IN.rd_n && HOST_REQ_IN.addr == ppp_pkg::PPP_OFS_CTRL) |=>
      RD_DATA_OUT[7:6] == 2'h0 && RD_DATA_OUT[5:0] == $past(st_q.ctrl))
    else $error("control read wrong");

  ctrl_pins_a: assert property (
    (wr_rise && st_q.waddr == ppp_pkg::PPP_OFS_CTRL) |=>
      {CHOOSE_PRINTER_N_OUT, INIT_N_OUT, LINE_FEED_AUTO_N_OUT, STROBE_N_OUT} ==
      ($past(st_q.wbus[3:0]) ^ 4'hB))
    else $error("control pins not following write");

  irq_raise_a: assert property (
    (ack_rise && st_d.ctrl[ppp_pkg::PPP_CTL_INTR]) |=> IRQ_OUT)
    else $error("ack rise did not raise interrupt");

  irq_off_a: assert property (
    !st_q.ctrl[ppp_pkg::PPP_CTL_INTR] |-> !IRQ_OUT)
    else $error("interrupt while disallowed");

  pin_dir_a: assert property (
    ##1 PRINTER_DATA_PINS_OE_N_OUT ==
      (!$past(MODE_CONFIG_REG_IN) && st_q.ctrl[ppp_pkg::PPP_CTL_DIR]))
    else $error("data pin direction wrong");

  status_ro_a: assert property (
    (wr_rise && st_q.waddr == ppp_pkg::PPP_OFS_STATE) |=>
      $stable(st_q.ctrl) && $stable(st_q.data))
    else $error("status write changed a register");

  // ------------------------------------------------------------------
  // checks on what must not move, and on where the interrupt comes from
  // ------------------------------------------------------------------
  // registers hold unless their own offset is written, so a stray strobe is caught

  data_keep_a: assert property (
    !(wr_rise && st_q.waddr == ppp_pkg::PPP_OFS_DATA) |=> $stable(PRINTER_DATA_PINS_OUT))
    else $error("data pins moved without a data write");

  ctrl_keep_a: assert property (
    !(wr_rise && st_q.waddr == ppp_pkg::PPP_OFS_CTRL) |=> $stable(st_q.ctrl))
    else $error("control changed without a control write");

  read_idle_a: assert property (
    HOST_REQ_IN.rd_n |=> RD_DATA_OUT == 8'h00)
    else $error("read answer not idle after strobe");

  spare_read_a: assert property (
    (!HOST_REQ_IN.rd_n && HOST_REQ_IN.addr == 2'h3) |=> RD_DATA_OUT == 8'h00)
    else $error("spare offset read not zero");

  irq_clear_a: assert property (
    (IRQ_OUT && rd_start && HOST_REQ_IN.addr == ppp_pkg::PPP_OFS_STATE && !ack_rise) |=>
      !IRQ_OUT)
    else $error("status read left interrupt pending");

  irq_hold_a: assert property (
    (IRQ_OUT && st_d.ctrl[ppp_pkg::PPP_CTL_INTR] &&
      !(rd_start && HOST_REQ_IN.addr == ppp_pkg::PPP_OFS_STATE)) |=> IRQ_OUT)
    else $error("interrupt dropped on its own");

  irq_cause_a: assert property (
    $rose(IRQ_OUT) |-> $past(ack_rise))
    else $error("interrupt raised without ack rise");

  // printer mode must drive whatever the direction bit holds
  printer_drive_a: assert property (
    MODE_CONFIG_REG_IN |=> !PRINTER_DATA_PINS_OE_N_OUT)
    else $error("pins released in printer mode");

endmodule

/* tb/ppp_port_bench.sv */
// self-checking bench for the printer port register block
// assumes one 125 MHz clock; the bench resolves the data wire
`timescale 1ns/1ns
module ppp_port_bench;
  logic clk = 1'b0; // system clock
  logic rst = 1'b1; // reset, active high
  ppp_pkg::ppp_host_req_t req = '{2'h0, 8'h00, 1'b1, 1'b1}; // host bus
  ppp_pkg::ppp_line_in_t line; // printer lines
  logic mode = 1'b1; // printer mode at start
  logic [2:0] levels = 3'b110; // fault_n, online, sheet
  logic [3:0] dly = 4'h9; // slow printer first
  logic [7:0] rdat, pout, pin, drv, got, d;
  logic oe_n, stb_n, af_n, init_n, ch_n, irq;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [10:0] rows [5] = '{11'h0C0, 11'h4C8, 11'h2D0, 11'h1E0, 11'h7F8}; // levels, status
  assign pin = oe_n ? drv : pout; // wire resolution
  always #4 clk = !clk;
  ppp_port DUT (.CLK_IN(clk), .RST_IN(rst), .HOST_REQ_IN(req), .RD_DATA_OUT(rdat),
    .LINE_IN(line), .MODE_CONFIG_REG_IN(mode), .PRINTER_DATA_PINS_IN(pin),
    .PRINTER_DATA_PINS_OUT(pout), .PRINTER_DATA_PINS_OE_N_OUT(oe_n),
    .STROBE_N_OUT(stb_n), .LINE_FEED_AUTO_N_OUT(af_n), .INIT_N_OUT(init_n),
    .CHOOSE_PRINTER_N_OUT(ch_n), .IRQ_OUT(irq));
  ppp_printer prn (.clk_in(clk), .strobe_n_in(stb_n), .pins_in(pin), .delay_in(dly),
    .levels_in(levels), .line_out(line), .drive_out(drv), .got_out(got));
  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  // write commits on the edge that sees the strobe high again
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk) begin
      req.addr <= a;
      req.wdata <= v;
      req.wr_n <= 1'b0;
    end
    @(posedge clk) req.wr_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk) begin
      req.addr <= a;
      req.rd_n <= 1'b0;
    end
    repeat (2) @(posedge clk);
    #1 v = rdat;
    @(posedge clk) req.rd_n <= 1'b1;
  endtask
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, far above the hundred and fifty or so cycles the tests take
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk8("data pins", 8'h00, pout);
    chk1("oe_n", 1'b0, oe_n);
    chk1("strobe_n", 1'b1, stb_n);
    chk1("autofeed_n", 1'b1, af_n);
    chk1("init_n", 1'b0, init_n);
    chk1("choose_n", 1'b1, ch_n);
    chk1("irq", 1'b0, irq);
    rd(2'h2, d);
    chk8("ctrl reset", 8'h00, d);
    // status levels straight from the lines, busy inverted
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) levels <= rows[i][10:8];
      rd(2'h1, d);
      chk8("status", rows[i][7:0], d);
    end
    wr(2'h2, 8'hEE);
    rd(2'h2, d);
    chk8("ctrl read", 8'h2E, d);
    chk1("strobe_n", 1'b1, stb_n);
    chk1("autofeed_n", 1'b0, af_n);
    chk1("init_n", 1'b1, init_n);
    chk1("choose_n", 1'b0, ch_n);
    chk1("oe_n printer mode", 1'b0, oe_n);
    wr(2'h0, 8'hA5);
    chk8("data pins", 8'hA5, pout);
    rd(2'h0, d);
    chk8("data read", 8'hA5, d);
    wr(2'h1, 8'h00);
    chk8("data kept", 8'hA5, pout);
    rd(2'h1, d);
    chk8("status write", 8'hF8, d);
    rd(2'h3, d);
    chk8("spare read", 8'h00, d);
    // extended mode honours the direction bit and releases the wire
    @(posedge clk) mode <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk1("oe_n input mode", 1'b1, oe_n);
    rd(2'h0, d);
    chk8("live data", 8'hC3, d);
    wr(2'h2, 8'h00);
    chk1("oe_n output", 1'b0, oe_n);
    // status frozen while the read strobe stays low
    @(posedge clk) begin
      levels <= 3'b110;
      req.addr <= 2'h1;
      req.rd_n <= 1'b0;
    end
    repeat (2) @(posedge clk);
    @(posedge clk) levels <= 3'b111;
    repeat (2) @(posedge clk);
    #1 chk8("held status", 8'hD8, rdat);
    @(posedge clk) req.rd_n <= 1'b1;
    // slow printer, interrupt allowed
    wr(2'h0, 8'h5A);
    wr(2'h2, 8'h11);
    chk1("strobe_n low", 1'b0, stb_n);
    rd(2'h1, d);
    chk8("busy status", 8'h78, d);
    wr(2'h2, 8'h10);
    // read status inside the ack pulse, two cycles wide at this delay
    while (line.ack_n) begin
      @(posedge clk);
      #1;
    end
    rd(2'h1, d);
    chk8("ack status", 8'h38, d);
    for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk);
    #1 chk1("irq raised", 1'b1, irq);
    chk8("printed byte", 8'h5A, got);
    rd(2'h1, d);
    chk1("irq cleared", 1'b0, irq);
    // prompt printer, interrupt not allowed
    @(posedge clk) dly <= 4'h2;
    wr(2'h2, 8'h01);
    wr(2'h2, 8'h00);
    repeat (20) @(posedge clk);
    #1 chk1("irq masked", 1'b0, irq);
    stop_test();
  end
endmodule

/* tb/ppp_printer.sv */
// printer model on the far side: data capture, busy and ack handshake
// assumes the bench resolves the data wire from the port's enable
`timescale 1ns/1ns
module ppp_printer #(
  parameter logic [7:0] SRC_BYTE = 8'hC3 // byte put on the wire when released
) (
  input wire logic clk_in,
  input wire logic strobe_n_in,
  input wire logic [7:0] pins_in,
  input wire logic [3:0] delay_in,
  input wire logic [2:0] levels_in,
  output ppp_pkg::ppp_line_in_t line_out,
  output logic [7:0] drive_out,
  output logic [7:0] got_out
);
  // ----------------------------------------------------------------
  // handshake state
  // ----------------------------------------------------------------
  logic [4:0] cnt_q = 5'h00; // cycles since strobe taken
  logic seen_q = 1'b0; // character in progress
  logic [4:0] dly; // ack start, slow or prompt
  assign dly = {1'b0, delay_in};
  // a strobe held low keeps the printer waiting, as a real one does
  always_ff @(posedge clk_in) begin
    if (!strobe_n_in && !seen_q) begin
      seen_q <= 1'b1;
      cnt_q <= 5'h00;
      got_out <= pins_in; // data taken without inversion
    end else if (seen_q) begin
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q >= dly + 5'h03 && strobe_n_in) begin
        seen_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // line levels
  // ----------------------------------------------------------------
  assign line_out.busy = seen_q;
  assign line_out.ack_n = !(seen_q && cnt_q >= dly && cnt_q < dly + 5'h02);
  assign line_out.fault_n = levels_in[2];
  assign line_out.online = levels_in[1];
  assign line_out.sheet_exhausted = levels_in[0];
  assign drive_out = SRC_BYTE; // only reaches the wire in input mode
endmodule
